// >>> hw/ises_pkg.sv
// constants, states and select-byte layout of the serial memory slave
package ises_pkg;

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int ISES_MEM_BYTES = 512;
    localparam int ISES_PAGE_BYTES = 16;
    localparam logic [8:0] ISES_ADDR_RST = 9'h000;
    localparam logic [8:0] ISES_ADDR_LAST = 9'h1ff;
    localparam logic [7:0] ISES_BYTE_RST = 8'h00;

    // ----------------------------------------------------------------
    // bus framing
    // ----------------------------------------------------------------
    localparam logic [3:0] ISES_TYPE_ID = 4'ha;
    localparam logic [3:0] ISES_ACK_SLOT = 4'h8;
    localparam logic [3:0] ISES_CNT_RST = 4'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int ISES_CLK_PERIOD_NS = 10;
    localparam int ISES_INTERNAL_PROGRAM_TIME_US = 5;
    // least time: round up to whole cycles
    localparam int ISES_PROG_CYCLES =
        (ISES_INTERNAL_PROGRAM_TIME_US * 1000 + ISES_CLK_PERIOD_NS - 1) /
        ISES_CLK_PERIOD_NS;
    localparam logic [19:0] ISES_BUSY_CNT_RST = 20'h00000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ISES_ST_IDLE  = 6'b000001,
        ISES_ST_DEV   = 6'b000010,
        ISES_ST_ADDR  = 6'b000100,
        ISES_ST_WDATA = 6'b001000,
        ISES_ST_RDATA = 6'b010000,
        ISES_ST_BUSY  = 6'b100000
    } ises_state_e;

    typedef struct packed {
        logic [3:0] type_id;
        logic [1:0] strap;
        logic addr_msb;
        logic rd;
    } ises_sel_s;

endpackage

// >>> hw/ises_eeprom_slave.sv
// serial-bus slave front end and 512-byte array of a byte-wide memory
`timescale 1ns/1ps
`default_nettype none

module ises_eeprom_slave #(
    parameter int PROG_CYCLES = ises_pkg::ISES_PROG_CYCLES,
    parameter bit FIVE_PIN = 1'b0
) (
    input wire logic clk_sys,            // system clock, 100 MHz
    input wire logic srst,               // synchronous reset, active high
    input wire logic scl,                // serial clock from the master
    input wire logic sda_i,              // serial data pin level
    output logic sda_o,                  // serial data drive value
    output logic sda_oe,                 // serial data pull-low enable
    input wire logic strap_select_low,   // strap for select bit b2
    input wire logic strap_select_high,  // strap for select bit b3
    input wire logic write_inhibit,      // high blocks array writes
    output logic busy                    // internal write cycle running
);
    import ises_pkg::*;

    // ----------------------------------------------------------------
    // link side: bit capture on the serial clock
    // ----------------------------------------------------------------
    // held a whole serial period, so the system side reads it safely
    // once it has seen the synchronised clock rise
    logic link_bit_r;

    always_ff @(posedge scl) begin
        link_bit_r <= sda_i;
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic scl_s1_r, scl_s2_r, scl_s3_r;
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    logic wi_s1_r, wi_s2_r;
    logic [1:0] strap_s1_r, strap_s2_r;

    always_ff @(posedge clk_sys) begin
        scl_s1_r <= scl;
        scl_s2_r <= scl_s1_r;
        scl_s3_r <= scl_s2_r;
        sda_s1_r <= sda_i;
        sda_s2_r <= sda_s1_r;
        sda_s3_r <= sda_s2_r;
        wi_s1_r <= write_inhibit;
        wi_s2_r <= wi_s1_r;
        strap_s1_r <= {strap_select_high, strap_select_low};
        strap_s2_r <= strap_s1_r;
    end

    // ----------------------------------------------------------------
    // bus events and decode
    // ----------------------------------------------------------------
    ises_state_e state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [8:0] addr_r, addr_nxt;
    logic msb_r, msb_nxt;
    logic oe_r, oe_nxt;
    logic wr_ok_r, wr_ok_nxt;
    logic [15:0] pvld_r, pvld_nxt;
    logic [19:0] busy_cnt_r, busy_cnt_nxt;
    logic [7:0] mem [ISES_MEM_BYTES];
    logic [7:0] pbuf [ISES_PAGE_BYTES];

    wire scl_rise = scl_s2_r & ~scl_s3_r;
    wire scl_fall = ~scl_s2_r & scl_s3_r;
    wire scl_high = scl_s2_r & scl_s3_r;
    wire start_det = scl_high & sda_s3_r & ~sda_s2_r;
    wire stop_det = scl_high & ~sda_s3_r & sda_s2_r;
    wire ack_slot = (cnt_r == ISES_ACK_SLOT);
    wire [1:0] strap_eff = FIVE_PIN ? 2'b00 : strap_s2_r;
    wire ises_sel_s sel = ises_sel_s'(rx_r);
    wire sel_match = (sel.type_id == ISES_TYPE_ID) &&
                     (sel.strap == strap_eff);
    // five-pin part holds at the top address instead of wrapping
    wire [8:0] addr_inc = (FIVE_PIN && addr_r == ISES_ADDR_LAST) ?
                          addr_r : addr_r + 9'h001;
    wire [8:0] addr_page_inc = {addr_r[8:4], addr_r[3:0] + 4'h1};
    wire [7:0] mem_cur = mem[addr_r];
    wire [7:0] mem_next = mem[addr_inc];
    wire [2:0] tx_idx = 3'd7 - cnt_r[2:0];
    wire in_commit = (state_r == ISES_ST_BUSY) && (busy_cnt_r < 20'd16);
    wire [3:0] commit_idx = busy_cnt_r[3:0];
    wire page_we = (state_r == ISES_ST_WDATA) && scl_fall && ack_slot &&
                   !start_det && !stop_det && !wi_s2_r;
    wire busy_done = (busy_cnt_r == 20'(PROG_CYCLES - 1));

    // ----------------------------------------------------------------
    // protocol engine
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        addr_nxt = addr_r;
        msb_nxt = msb_r;
        oe_nxt = oe_r;
        wr_ok_nxt = wr_ok_r;
        pvld_nxt = pvld_r;
        busy_cnt_nxt = busy_cnt_r;
        if (state_r == ISES_ST_BUSY) begin
            oe_nxt = 1'b0;
            busy_cnt_nxt = busy_cnt_r + 20'h00001;
            if (busy_done) begin
                state_nxt = ISES_ST_IDLE;
                busy_cnt_nxt = ISES_BUSY_CNT_RST;
                pvld_nxt = '0;
                // addr_r already sits past the last byte taken
            end
        end else if (start_det) begin
            state_nxt = ISES_ST_DEV;
            cnt_nxt = ISES_CNT_RST;
            oe_nxt = 1'b0;
            wr_ok_nxt = 1'b0;
        end else if (stop_det) begin
            oe_nxt = 1'b0;
            cnt_nxt = ISES_CNT_RST;
            wr_ok_nxt = 1'b0;
            if (wr_ok_r) begin
                state_nxt = ISES_ST_BUSY;
            end else begin
                state_nxt = ISES_ST_IDLE;
                pvld_nxt = '0;
            end
        end else if (state_r != ISES_ST_IDLE && scl_rise) begin
            if (!ack_slot) begin
                cnt_nxt = cnt_r + 4'h1;
                rx_nxt = {rx_r[6:0], link_bit_r};
                // the rise of the tenth slot keeps the write armed
                if (cnt_r != ISES_CNT_RST) begin
                    wr_ok_nxt = 1'b0;
                end
            end else begin
                cnt_nxt = ISES_CNT_RST;
                // own select ack has oe_r high: no byte went out yet
                if (state_r == ISES_ST_RDATA && !oe_r) begin
                    addr_nxt = addr_inc;
                    tx_nxt = mem_next;
                    if (link_bit_r) begin
                        state_nxt = ISES_ST_IDLE;
                        oe_nxt = 1'b0;
                    end
                end
            end
        end else if (state_r != ISES_ST_IDLE && scl_fall) begin
            if (ack_slot) begin
                case (state_r)
                    ISES_ST_DEV: begin
                        if (sel_match && sel.rd) begin
                            oe_nxt = 1'b1;
                            state_nxt = ISES_ST_RDATA;
                            tx_nxt = mem_cur;
                        end else if (sel_match) begin
                            oe_nxt = 1'b1;
                            state_nxt = ISES_ST_ADDR;
                            msb_nxt = sel.addr_msb;
                        end else begin
                            oe_nxt = 1'b0;
                            state_nxt = ISES_ST_IDLE;
                        end
                    end
                    ISES_ST_ADDR: begin
                        oe_nxt = 1'b1;
                        addr_nxt = {msb_r, rx_r};
                        state_nxt = ISES_ST_WDATA;
                    end
                    ISES_ST_WDATA: begin
                        if (wi_s2_r) begin
                            oe_nxt = 1'b0;
                        end else begin
                            oe_nxt = 1'b1;
                            wr_ok_nxt = 1'b1;
                            pvld_nxt[addr_r[3:0]] = 1'b1;
                            addr_nxt = addr_page_inc;
                        end
                    end
                    default: begin
                        oe_nxt = 1'b0;
                    end
                endcase
            end else if (state_r == ISES_ST_RDATA) begin
                oe_nxt = ~tx_r[tx_idx];
            end else begin
                oe_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= ISES_ST_IDLE;
            cnt_r <= ISES_CNT_RST;
            rx_r <= ISES_BYTE_RST;
            tx_r <= ISES_BYTE_RST;
            addr_r <= ISES_ADDR_RST;
            msb_r <= 1'b0;
            oe_r <= 1'b0;
            wr_ok_r <= 1'b0;
            pvld_r <= '0;
            busy_cnt_r <= ISES_BUSY_CNT_RST;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            addr_r <= addr_nxt;
            msb_r <= msb_nxt;
            oe_r <= oe_nxt;
            wr_ok_r <= wr_ok_nxt;
            pvld_r <= pvld_nxt;
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // page buffer and array
    // ----------------------------------------------------------------
    // bytes wait in the page buffer so the array changes only once
    // the stop has confirmed the write
    always_ff @(posedge clk_sys) begin
        if (page_we) begin
            pbuf[addr_r[3:0]] <= rx_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (in_commit && pvld_r[commit_idx]) begin
            mem[{addr_r[8:4], commit_idx}] <= pbuf[commit_idx];
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = oe_r;
    assign busy = state_r[5];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_BUSY_SILENT: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r == ISES_ST_BUSY) |-> !sda_oe)
        else $error("data driven during write cycle");

    AST_START_SEEN: assert property (
        @(posedge clk_sys) disable iff (srst)
        (start_det && state_r != ISES_ST_BUSY) |=>
        (state_r == ISES_ST_DEV) && (cnt_r == ISES_CNT_RST))
        else $error("start not taken");

    AST_STOP_STANDBY: assert property (
        @(posedge clk_sys) disable iff (srst)
        (stop_det && !wr_ok_r && state_r != ISES_ST_BUSY) |=>
        (state_r == ISES_ST_IDLE) && !sda_oe)
        else $error("stop did not return to standby");

    AST_STOP_WRITES: assert property (
        @(posedge clk_sys) disable iff (srst)
        (stop_det && wr_ok_r && state_r == ISES_ST_WDATA) |=>
        busy && (busy_cnt_r == ISES_BUSY_CNT_RST))
        else $error("write cycle not started");

    AST_INHIBIT_NOACK: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r == ISES_ST_WDATA && scl_fall && ack_slot && wi_s2_r &&
         !start_det && !stop_det) |=> !sda_oe && !wr_ok_r)
        else $error("inhibited data byte acknowledged");

    AST_SELECT_ACK: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r == ISES_ST_DEV && scl_fall && ack_slot && !start_det &&
         !stop_det) |=> (sda_oe == $past(sel_match)))
        else $error("select ack does not follow match");

    AST_ADDR_ACK: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r == ISES_ST_ADDR && scl_fall && ack_slot && !start_det &&
         !stop_det) |=> sda_oe && (addr_r[7:0] == $past(rx_r)))
        else $error("address byte not acknowledged");

    AST_NACK_RELEASE: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r == ISES_ST_RDATA && scl_rise && ack_slot && link_bit_r &&
         !start_det && !stop_det) |=> (state_r == ISES_ST_IDLE) && !sda_oe)
        else $error("no standby after missing ack");

    AST_READ_ADVANCE: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r == ISES_ST_RDATA && scl_rise && ack_slot && !sda_oe &&
         !start_det && !stop_det && !FIVE_PIN) |=>
        (addr_r == $past(addr_r) + 9'h001))
        else $error("read counter did not advance");

    AST_BUSY_LENGTH: assert property (
        @(posedge clk_sys) disable iff (srst)
        busy |=> (busy == !$past(busy_done)))
        else $error("write cycle length wrong");

    AST_BUSY_DEAF: assert property (
        @(posedge clk_sys) disable iff (srst)
        (busy && !busy_done && (start_det || stop_det)) |=> busy && !sda_oe)
        else $error("bus event taken during write cycle");

    AST_IDLE_QUIET: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r == ISES_ST_IDLE) |-> !sda_oe)
        else $error("data driven in standby");

    AST_CAPTURE: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r inside {ISES_ST_DEV, ISES_ST_ADDR, ISES_ST_WDATA} &&
         scl_rise && !ack_slot && !start_det && !stop_det) |=>
        (rx_r[0] == $past(link_bit_r)))
        else $error("incoming bit not captured");

    AST_RX_QUIET: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r inside {ISES_ST_DEV, ISES_ST_ADDR, ISES_ST_WDATA} &&
         scl_fall && !ack_slot && !start_det && !stop_det) |=> !sda_oe)
        else $error("data driven while receiving");

    AST_READ_BIT: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r == ISES_ST_RDATA && scl_fall && !ack_slot && !start_det &&
         !stop_det) |=> (sda_oe == !$past(tx_r[tx_idx])))
        else $error("output bit wrong");

    AST_DATA_RELEASE: assert property (
        @(posedge clk_sys) disable iff (srst)
        (state_r == ISES_ST_RDATA && scl_fall && ack_slot && !start_det &&
         !stop_det) |=> !sda_oe)
        else $error("data not released for master ack");

    AST_PAGE_HOLD: assert property (
        @(posedge clk_sys) disable iff (srst)
        page_we |=> (addr_r[8:4] == $past(addr_r[8:4])))
        else $error("page write left its page");

    AST_PAGE_STEP: assert property (
        @(posedge clk_sys) disable iff (srst)
        page_we |=> (addr_r[3:0] == $past(addr_r[3:0]) + 4'h1))
        else $error("in-page counter did not advance");

endmodule

`default_nettype wire

// >>> sim/ises_master_model.sv
// serial bus master model: clock, data drive and byte tasks
`timescale 1ns/1ps
`default_nettype none
module ises_master_model (
    input wire logic clk_link,  // timing base of the link, 48 ns
    input wire logic sda_i,     // resolved level of the data wire
    output logic scl,           // serial clock, idles high
    output logic master_oe      // high while the master pulls data low
);
    initial begin
        scl = 1'b1;
        master_oe = 1'b0;
    end

    // ---------------------------------------------------------------
    // bus conditions
    // ---------------------------------------------------------------
    // five link ticks per phase keeps scl phases far above 40 ns
    task automatic tick(input int n);
        repeat (n) @(posedge clk_link);
        #1;
    endtask

    task automatic start_c();
        tick(2);
        master_oe = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        master_oe = 1'b1;
        tick(3);
        scl = 1'b0;
    endtask

    task automatic stop_c();
        tick(2);
        master_oe = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(3);
        master_oe = 1'b0;
        tick(3);
    endtask

    // data moves only with scl low, sampled at the rise
    task automatic bit_c(input logic b, output logic s);
        tick(2);
        master_oe = ~b;
        tick(3);
        s = sda_i;
        scl = 1'b1;
        tick(5);
        scl = 1'b0;
    endtask

    // ---------------------------------------------------------------
    // bytes
    // ---------------------------------------------------------------
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_c(d[i], s);
        bit_c(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic ack_m, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, s);
            d[i] = s;
        end
        bit_c(~ack_m, s);
    endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ises_pkg::*;
    localparam int PROG = 1000;
    logic clk_sys, clk_link, srst, scl, master_oe, sda_o, sda_oe, busy;
    logic strap_lo, strap_hi, write_inhibit;
    logic [1:0] strap;
    logic sda_o5, sda_oe5, busy5;
    wire logic sda_w;
    wire logic busy_any;
    int bad_count, compares, busy_len, busy_last;

    // pull-up wire, every party open drain
    assign sda_w = ~((sda_oe & ~sda_o) | (sda_oe5 & ~sda_o5) | master_oe);
    assign busy_any = busy | busy5;

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #7;
        forever #24 clk_link = ~clk_link;
    end

    ises_eeprom_slave #(.PROG_CYCLES(PROG), .FIVE_PIN(1'b0)) u_dut (
        .clk_sys(clk_sys), .srst(srst), .scl(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .strap_select_low(strap_lo),
        .strap_select_high(strap_hi), .write_inhibit(write_inhibit),
        .busy(busy));
    // second part on the same wire, straps absent and read as 00
    ises_eeprom_slave #(.PROG_CYCLES(PROG), .FIVE_PIN(1'b1)) u_dut_five (
        .clk_sys(clk_sys), .srst(srst), .scl(scl), .sda_i(sda_w),
        .sda_o(sda_o5), .sda_oe(sda_oe5), .strap_select_low(1'b0),
        .strap_select_high(1'b0), .write_inhibit(write_inhibit),
        .busy(busy5));
    ises_master_model u_master (.clk_link(clk_link), .sda_i(sda_w),
        .scl(scl), .master_oe(master_oe));

    always @(posedge clk_sys) begin
        if (busy_any === 1'b1) begin
            busy_len <= busy_len + 1;
        end else if (busy_len != 0) begin
            busy_last <= busy_len;
            busy_len <= 0;
        end
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    function automatic logic [7:0] sel(input logic a8, input logic rd);
        return {ISES_TYPE_ID, strap, a8, rd};
    endfunction

    // write, then poll with start and select until acked
    task automatic wr(input logic [8:0] a, input int n, input logic [7:0] d0);
        logic ack;
        int polls;
        u_master.start_c();
        u_master.send_byte(sel(a[8], 1'b0), ack);
        chk(16'(ack), 16'h0001);
        u_master.send_byte(a[7:0], ack);
        chk(16'(ack), 16'h0001);
        for (int i = 0; i < n; i++) begin
            u_master.send_byte(d0 + 8'(i), ack);
            chk(16'(ack), 16'(!write_inhibit));
        end
        u_master.stop_c();
        repeat (8) @(posedge clk_sys);
        chk(16'(busy_any), 16'(!write_inhibit));
        polls = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && polls < 20) begin
            u_master.start_c();
            u_master.send_byte(sel(1'b0, 1'b0), ack);
            polls++;
        end
        u_master.stop_c();
        chk(16'(ack), 16'h0001);
        if (!write_inhibit) begin
            chk(16'(polls > 1), 16'h0001);
            chk(16'(busy_last), 16'(PROG));
        end
    endtask

    task automatic rd_go(input logic rnd, input logic [8:0] a);
        logic ack;
        u_master.start_c();
        if (rnd) begin
            u_master.send_byte(sel(a[8], 1'b0), ack);
            u_master.send_byte(a[7:0], ack);
            chk(16'(ack), 16'h0001);
            u_master.start_c();
        end
        u_master.send_byte(sel(1'b0, 1'b1), ack);
        chk(16'(ack), 16'h0001);
    endtask

    task automatic rd_byte(input logic [7:0] exp, input logic last);
        logic [7:0] d;
        u_master.recv_byte(~last, d);
        chk(16'(d), 16'(exp));
        if (last) u_master.stop_c();
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_byte();
        wr(9'h155, 1, 8'h3c);
        rd_go(1'b1, 9'h155);
        rd_byte(8'h3c, 1'b1);
        $display("test byte write done");
    endtask

    // 18 bytes from 0x0fe wrap in page; counter ends at page start
    task automatic t_page();
        wr(9'h0fe, 18, 8'h40);
        rd_go(1'b0, 9'h000);
        for (int j = 0; j < 16; j++) rd_byte(8'h42 + 8'(j), j == 15);
        $display("test page roll-over done");
    endtask

    task automatic t_inhibit();
        @(posedge clk_sys);
        #1 write_inhibit = 1'b1;
        repeat (4) @(posedge clk_sys);
        wr(9'h155, 2, 8'hc3);
        rd_go(1'b1, 9'h155);
        rd_byte(8'h3c, 1'b1);
        @(posedge clk_sys);
        #1 write_inhibit = 1'b0;
        $display("test write inhibit done");
    endtask

    // stop after the address byte, then stop in mid data byte
    task automatic t_abort();
        logic ack, s;
        for (int k = 0; k < 2; k++) begin
            u_master.start_c();
            u_master.send_byte(sel(1'b1, 1'b0), ack);
            u_master.send_byte(8'h55, ack);
            if (k == 1) for (int i = 0; i < 4; i++) u_master.bit_c(1'b0, s);
            u_master.stop_c();
            repeat (8) @(posedge clk_sys);
            chk(16'(busy), 16'h0000);
        end
        rd_go(1'b1, 9'h155);
        rd_byte(8'h3c, 1'b1);
        $display("test aborted write done");
    endtask

    task automatic t_select();
        logic ack;
        logic [7:0] bad [2];
        bad = '{8'hb8, 8'ha4};
        for (int k = 0; k < 2; k++) begin
            u_master.start_c();
            u_master.send_byte(bad[k], ack);
            chk(16'(ack), 16'h0000);
            u_master.stop_c();
        end
        @(posedge clk_sys);
        #1 strap_lo = 1'b1;
        strap_hi = 1'b0;
        strap = 2'b01;
        repeat (4) @(posedge clk_sys);
        rd_go(1'b1, 9'h155);
        rd_byte(8'h3c, 1'b1);
        $display("test device select done");
    endtask

    task automatic t_wrap();
        wr(9'h1ff, 1, 8'ha5);
        wr(9'h000, 1, 8'h5a);
        rd_go(1'b1, 9'h1ff);
        rd_byte(8'ha5, 1'b0);
        rd_byte(8'h5a, 1'b1);
        $display("test read wrap done");
    endtask

    // five-pin part: counter holds at the top address
    task automatic t_five();
        strap = 2'b00;
        wr(9'h1ff, 1, 8'h77);
        rd_go(1'b1, 9'h1ff);
        rd_byte(8'h77, 1'b0);
        rd_byte(8'h77, 1'b1);
        $display("test five-pin part done");
    endtask

    initial begin
        srst = 1'b1;
        write_inhibit = 1'b0;
        strap_lo = 1'b0;
        strap_hi = 1'b1;
        strap = 2'b10;
        repeat (5) @(posedge clk_sys);
        #1 srst = 1'b0;
        repeat (8) @(posedge clk_sys);
        t_byte();
        t_page();
        t_inhibit();
        t_abort();
        t_select();
        t_wrap();
        t_five();
        results();
    end

    // full run is near 0.47 ms of link traffic
    initial begin
        #700000;
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
